// >>> design/gate_dead_time.sv
// Totem-pole gate driver sequencer with break-before-make dead time.
// Assumes on_req comes from logic on the same clock.
`timescale 1ns/1ns
module gate_dead_time
  import pwm_pkg::*;
#(
  parameter int unsigned DEAD = DEAD_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  gate_drive_if.drv drv
);
  localparam int DW = $clog2(DEAD + 1);
  logic [DW-1:0] dead_r;
  logic pu_r;
  logic pd_r;

  // Each stage is released only after the other has been off for the dead count
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      pu_r <= 1'b0;
      pd_r <= 1'b1;
      dead_r <= '0;
    end else if (drv.on_req) begin
      if (pd_r) begin
        pd_r <= 1'b0;
        dead_r <= DW'(DEAD);
      end else if (!pu_r) begin
        if (dead_r != '0) dead_r <= dead_r - 1'b1;
        else pu_r <= 1'b1;
      end
    end else begin
      if (pu_r) begin
        pu_r <= 1'b0;
        dead_r <= DW'(DEAD);
      end else if (!pd_r) begin
        if (dead_r != '0) dead_r <= dead_r - 1'b1;
        else pd_r <= 1'b1;
      end
    end
  end

  assign drv.pullup_on = pu_r;
  assign drv.pulldown_on = pd_r;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  AST_NO_SHOOT_THROUGH: assert property (!(pu_r && pd_r))
    else $error("Pull-up and pull-down on together");
  AST_DEAD_BEFORE_PULLUP: assert property ($rose(pu_r) |-> !$past(pd_r) && !$past(pd_r, 2))
    else $error("Pull-up rose without dead interval");
  AST_DEAD_BEFORE_PULLDOWN: assert property ($rose(pd_r) |-> !$past(pu_r) && !$past(pu_r, 2))
    else $error("Pull-down rose without dead interval");
endmodule

// >>> design/pwm_protect_ctrl.sv
// Fixed-frequency current-mode PWM control with protection sequencing.
// Assumes comparator levels from the analog front end, asynchronous to i_ref_clk.
//
// Functional notes
// - Switching period from internal counter at fixed 55 kHz, no external setting.
// - On-time ends when sensed current reaches the current limit after blanking, every cycle.
// - Blanking opens at each on-time start; limit comparator ignored meanwhile.
// - Duty set by sense and feedback; on-time ends at the feedback crossing.
// - Period-synchronous compensation ramp is added to sensed current before comparison.
// - Push-pull driver stages never conduct together; dead interval on each edge.
// - Feedback over power limit longer than debounce time stops switching.
// - After overload stop, stay off until undervoltage lockout, then restart.
// - Over-temperature turns the switch off and keeps switching stopped until undervoltage lockout, then restart.
// - Supply over 29 V holds switch off until below 8 V, then restarts.
// - Every start begins with 4 ms soft start ramping the current limit.
// - Below burst threshold, switch only while supply is low.
`timescale 1ns/1ns
module pwm_protect_ctrl
  import pwm_pkg::*;
#(
  parameter int unsigned PERIOD = PERIOD_CYC,
  parameter int unsigned SOFT_CYC = SOFT_START_CYC,
  parameter int unsigned DEBOUNCE = OVERLOAD_DEBOUNCE_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_cs_limit_trip,
  input wire logic i_pwm_trip,
  input wire logic i_fb_overload,
  input wire logic i_fb_burst_low,
  input wire logic i_vdd_below_supply_undervoltage_lockout,
  input wire logic i_vdd_over_ovp,
  input wire logic i_vdd_below_restart,
  input wire logic i_vdd_below_burst,
  input wire logic i_over_temp,
  output logic o_pullup_on,
  output logic o_pulldown_on,
  output logic [7:0] o_cs_limit_code,
  output logic [7:0] o_slope_code,
  output logic o_switching
);
  localparam int PW = $clog2(PERIOD + 1);
  localparam int BW = $clog2(BLANK_CYC + 1);
  localparam int DBW = $clog2(DEBOUNCE + 1);
  localparam int unsigned MAX_ON = (PERIOD * MAX_DUTY_PCT) / 100;
  localparam int unsigned SLOPE_STEP = (PERIOD / CODE_STEPS > 0) ? PERIOD / CODE_STEPS : 1;
  localparam int unsigned SS_STEP = (SOFT_CYC / CODE_STEPS > 0) ? SOFT_CYC / CODE_STEPS : 1;
  localparam int SLW = $clog2(SLOPE_STEP + 1);
  localparam int SSW = $clog2(SS_STEP + 1);

  logic [N_IN-1:0] meta_r;
  logic [N_IN-1:0] sync_r;
  ctl_state_e state_r;
  ctl_state_e state_nxt;
  logic [PW-1:0] period_r;
  logic [BW-1:0] blank_r;
  logic [DBW-1:0] ol_cnt_r;
  logic [SLW-1:0] slope_div_r;
  logic [SSW-1:0] ss_div_r;
  logic [7:0] slope_r;
  logic [7:0] limit_r;
  logic on_r;
  logic wrap;
  logic blanking;
  logic switching;
  logic stop_now;
  logic trip_ok;
  logic burst_ok;
  logic ol_trip;
  logic start_on;
  logic max_hit;

  gate_drive_if drv_bus ();

  gate_dead_time #(
    .DEAD(DEAD_CYC)
  ) u_driver (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .drv(drv_bus.drv)
  );

  // All comparator levels are asynchronous to this clock
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      meta_r <= SYNC_RST;
      sync_r <= SYNC_RST;
    end else begin
      meta_r <= {i_over_temp, i_vdd_below_burst, i_vdd_below_restart, i_vdd_over_ovp,
                 i_vdd_below_supply_undervoltage_lockout, i_fb_burst_low, i_fb_overload, i_pwm_trip, i_cs_limit_trip};
      sync_r <= meta_r;
    end
  end

  assign switching = (state_r == ST_SOFT) || (state_r == ST_RUN);
  assign wrap = (period_r == PW'(PERIOD - 1));
  assign blanking = (blank_r != '0);
  assign max_hit = (period_r == PW'(MAX_ON));
  assign ol_trip = sync_r[IN_OVERLOAD] && (ol_cnt_r == DBW'(DEBOUNCE));
  // Faults cut the on-time at once instead of waiting for the state update
  assign stop_now = !switching || sync_r[IN_OVP] || sync_r[IN_OTP] || ol_trip;
  assign trip_ok = !blanking && (sync_r[IN_CS_LIMIT] || sync_r[IN_PWM_TRIP]);
  assign burst_ok = !sync_r[IN_BURST_LOW] || sync_r[IN_VDD_LOW];
  assign start_on = wrap && burst_ok && !stop_now;

  // Free-running period counter, no external timing input
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) period_r <= '0;
    else if (wrap) period_r <= '0;
    else period_r <= period_r + 1'b1;
  end

  always_comb begin
    state_nxt = state_r;
    if (sync_r[IN_OVP] && state_r != ST_OVP) begin
      state_nxt = ST_OVP;
    end else if (sync_r[IN_OTP] && state_r != ST_OVP && state_r != ST_OTP) begin
      state_nxt = ST_OTP;
    end else begin
      case (state_r)
        ST_LOCKOUT: if (!sync_r[IN_SUPPLY_UNDERVOLTAGE_LOCKOUT]) state_nxt = ST_SOFT;
        ST_SOFT: begin
          if (sync_r[IN_SUPPLY_UNDERVOLTAGE_LOCKOUT]) state_nxt = ST_LOCKOUT;
          else if (ol_trip) state_nxt = ST_OLP;
          else if (limit_r == CODE_MAX) state_nxt = ST_RUN;
        end
        ST_RUN: begin
          if (sync_r[IN_SUPPLY_UNDERVOLTAGE_LOCKOUT]) state_nxt = ST_LOCKOUT;
          else if (ol_trip) state_nxt = ST_OLP;
        end
        ST_OLP: if (sync_r[IN_SUPPLY_UNDERVOLTAGE_LOCKOUT]) state_nxt = ST_LOCKOUT;
        ST_OTP: if (sync_r[IN_SUPPLY_UNDERVOLTAGE_LOCKOUT]) state_nxt = ST_LOCKOUT;
        ST_OVP: if (sync_r[IN_RESTART]) state_nxt = ST_SOFT;
        default: state_nxt = ST_LOCKOUT;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) state_r <= ST_LOCKOUT;
    else state_r <= state_nxt;
  end

  // Counts consecutive overload samples; any dip restarts the debounce
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) ol_cnt_r <= '0;
    else if (!sync_r[IN_OVERLOAD] || !switching) ol_cnt_r <= '0;
    else if (ol_cnt_r != DBW'(DEBOUNCE)) ol_cnt_r <= ol_cnt_r + 1'b1;
  end

  // Soft start ramps the peak-current limit code from zero to full scale
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      limit_r <= CODE_RST;
      ss_div_r <= '0;
    end else if (state_r == ST_RUN) begin
      limit_r <= CODE_MAX;
      ss_div_r <= '0;
    end else if (state_r != ST_SOFT) begin
      limit_r <= CODE_RST;
      ss_div_r <= '0;
    end else if (ss_div_r == SSW'(SS_STEP - 1)) begin
      ss_div_r <= '0;
      if (limit_r != CODE_MAX) limit_r <= limit_r + 8'h01;
    end else begin
      ss_div_r <= ss_div_r + 1'b1;
    end
  end

  // Ramp restarts every period so it stays locked to the oscillator
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      slope_r <= CODE_RST;
      slope_div_r <= '0;
    end else if (wrap || !on_r) begin
      slope_r <= CODE_RST;
      slope_div_r <= '0;
    end else if (slope_div_r == SLW'(SLOPE_STEP - 1)) begin
      slope_div_r <= '0;
      if (slope_r != CODE_MAX) slope_r <= slope_r + 8'h01;
    end else begin
      slope_div_r <= slope_div_r + 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) on_r <= 1'b0;
    else if (stop_now) on_r <= 1'b0;
    // A trip still high from the last period must not veto the start; blanking masks it
    else if (start_on) on_r <= 1'b1;
    else if (trip_ok || max_hit) on_r <= 1'b0;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) blank_r <= '0;
    else if (start_on) blank_r <= BW'(BLANK_CYC);
    else if (blanking) blank_r <= blank_r - 1'b1;
  end

  assign drv_bus.on_req = on_r;
  assign o_pullup_on = drv_bus.pullup_on;
  assign o_pulldown_on = drv_bus.pulldown_on;
  assign o_cs_limit_code = limit_r;
  assign o_slope_code = slope_r;
  assign o_switching = switching;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  AST_PERIOD_WRAP: assert property (wrap |=> period_r == '0 ##1 period_r == PW'(1))
    else $error("Period counter did not wrap");
  AST_CURRENT_LIMIT_ENDS_ON: assert property (on_r && !blanking && sync_r[IN_CS_LIMIT] |=> !on_r)
    else $error("Current limit did not end on-time");
  AST_BLANKING_HOLDS_ON: assert property (on_r && blanking && !stop_now && !max_hit |=> on_r)
    else $error("On-time ended inside blanking");
  AST_BLANK_LENGTH: assert property ($rose(on_r) |-> (blank_r == BW'(BLANK_CYC)) ##0 blanking [*8])
    else $error("Blanking shorter than expected");
  AST_FEEDBACK_ENDS_ON: assert property (on_r && !blanking && sync_r[IN_PWM_TRIP] |=> !on_r)
    else $error("Feedback crossing did not end on-time");
  AST_SLOPE_ZERO_OFF: assert property (!on_r |=> slope_r == CODE_RST)
    else $error("Ramp not reset outside on-time");
  AST_OVERLOAD_SHUTDOWN: assert property (switching && ol_trip && !sync_r[IN_OVP] && !sync_r[IN_OTP] && !sync_r[IN_SUPPLY_UNDERVOLTAGE_LOCKOUT]
    |=> state_r == ST_OLP && !on_r)
    else $error("Overload debounce expiry did not stop switching");
  AST_SHORT_OVERLOAD: assert property (switching && $fell(sync_r[IN_OVERLOAD]) |=> ol_cnt_r == '0)
    else $error("Debounce not restarted by short excursion");
  AST_OLP_HOLD: assert property (state_r == ST_OLP && !sync_r[IN_SUPPLY_UNDERVOLTAGE_LOCKOUT] && !sync_r[IN_OVP] && !sync_r[IN_OTP]
    |=> state_r == ST_OLP)
    else $error("Overload latch left without lockout");
  AST_OTP_OFF: assert property (sync_r[IN_OTP] |=> !on_r ##1 !o_pullup_on)
    else $error("Over-temperature did not turn switch off");
  AST_OVP_RESTART: assert property (state_r == ST_OVP && sync_r[IN_RESTART] && !sync_r[IN_OVP]
    |=> state_r == ST_SOFT && limit_r == CODE_RST)
    else $error("Over-voltage exit did not enter soft start");
  AST_SOFT_FROM_ZERO: assert property (state_r == ST_LOCKOUT && !sync_r[IN_SUPPLY_UNDERVOLTAGE_LOCKOUT] && !sync_r[IN_OVP]
    && !sync_r[IN_OTP] |=> state_r == ST_SOFT ##1 limit_r == CODE_RST)
    else $error("Soft start did not begin at zero limit");
  AST_BURST_GATE: assert property ($rose(on_r) |-> !$past(sync_r[IN_BURST_LOW]) || $past(sync_r[IN_VDD_LOW]))
    else $error("Burst mode switched with supply high");
  AST_FAULT_FORCES_OFF: assert property (!switching |=> !on_r)
    else $error("Driver on while a fault is latched");

  COV_FULL_PULSE: cover property ($rose(on_r) ##[1:1000] $fell(on_r));
  COV_OLP_ENTRY: cover property (state_r == ST_RUN ##1 state_r == ST_OLP);
  COV_OVP_RESTART: cover property (state_r == ST_OVP ##1 state_r == ST_SOFT);
  COV_BURST_SKIP: cover property (wrap && !burst_ok && switching);
endmodule

// >>> pkg/gate_drive_if.sv
// Carrier between the PWM control and the totem-pole driver stage.
// Assumes both ends share one clock.
`timescale 1ns/1ns
interface gate_drive_if;
  logic on_req;
  logic pullup_on;
  logic pulldown_on;
  modport ctrl (output on_req, input pullup_on, input pulldown_on);
  modport drv (input on_req, output pullup_on, output pulldown_on);
endinterface

// >>> pkg/pwm_pkg.sv
// Shared constants and types for the current-mode switcher control block.
// Assumes a single 250 MHz clock and comparator levels that arrive asynchronously.
package pwm_pkg;
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned CLK_NS = 4;
  localparam int unsigned SW_FREQ_HZ = 55_000;
  localparam int unsigned PERIOD_CYC = CLK_HZ / SW_FREQ_HZ;
  localparam int unsigned MAX_DUTY_PCT = 75;
  localparam int unsigned BLANK_NS = 270;
  localparam int unsigned BLANK_CYC = (BLANK_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned DEAD_NS = 8;
  localparam int unsigned DEAD_CYC = (DEAD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SOFT_START_MS = 4;
  localparam int unsigned SOFT_START_CYC = SOFT_START_MS * (CLK_HZ / 1000);
  localparam int unsigned OVERLOAD_DEBOUNCE_MS = 50;
  localparam int unsigned OVERLOAD_DEBOUNCE_CYC = OVERLOAD_DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int unsigned CODE_STEPS = 255;
  localparam logic [7:0] CODE_MAX = 8'hff;
  localparam logic [7:0] CODE_RST = 8'h00;
  // Index of each comparator level in the synchroniser vector
  localparam int IN_CS_LIMIT = 0;
  localparam int IN_PWM_TRIP = 1;
  localparam int IN_OVERLOAD = 2;
  localparam int IN_BURST_LOW = 3;
  localparam int IN_SUPPLY_UNDERVOLTAGE_LOCKOUT = 4;
  localparam int IN_OVP = 5;
  localparam int IN_RESTART = 6;
  localparam int IN_VDD_LOW = 7;
  localparam int IN_OTP = 8;
  localparam int N_IN = 9;
  // Lockout asserted until the real supply level has been sampled
  localparam logic [8:0] SYNC_RST = 9'h010;
  typedef enum logic [2:0] {ST_LOCKOUT, ST_SOFT, ST_RUN, ST_OLP, ST_OTP, ST_OVP} ctl_state_e;
endpackage

// >>> test/current_mode_pwm_protection_bench.sv
// Self-checking bench for the PWM control block with reduced counts.
// Assumes the power stage model closes the current loop.
`timescale 1ns/1ns
module current_mode_pwm_protection_bench;
  import pwm_pkg::*;
  localparam int PER = 300;
  localparam int SOFT = 600;
  localparam int DEB = 50;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ovl = 1'b0, bl = 1'b0, supply_undervoltage_lockout = 1'b1, supply_overvoltage_shutdown = 1'b0, rst8 = 1'b0, bb = 1'b0, otp = 1'b0;
  logic force_cs = 1'b0;
  logic [7:0] fb = 8'hff;
  logic cs_trip, pwm_trip, pu, pd, sw;
  logic [7:0] lim, slope;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  always #2 clk = ~clk;
  pwm_protect_ctrl #(.PERIOD(PER), .SOFT_CYC(SOFT), .DEBOUNCE(DEB)) dut_u (.i_ref_clk(clk), .i_rst_b(rst_b),
    .i_cs_limit_trip(cs_trip), .i_pwm_trip(pwm_trip), .i_fb_overload(ovl), .i_fb_burst_low(bl),
    .i_vdd_below_supply_undervoltage_lockout(supply_undervoltage_lockout), .i_vdd_over_ovp(supply_overvoltage_shutdown), .i_vdd_below_restart(rst8), .i_vdd_below_burst(bb),
    .i_over_temp(otp), .o_pullup_on(pu), .o_pulldown_on(pd), .o_cs_limit_code(lim), .o_slope_code(slope),
    .o_switching(sw));
  power_stage_model stage_u (.i_ref_clk(clk), .i_pullup_on(pu), .i_cs_limit_code(lim), .i_slope_code(slope),
    .i_fb_level(fb), .i_force_cs(force_cs), .o_cs_trip(cs_trip), .o_pwm_trip(pwm_trip));
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int v, input int lo, input int hi);
    n_compared++;
    if (v < lo || v > hi) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h..%h", $time, v, lo, hi);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Width of the next gate pulse; 0 when none starts within two periods
  task automatic pulse(output int w);
    int i;
    w = 0;
    // Skip a pulse already in progress so only whole pulses are measured
    for (i = 0; i < PER && pu === 1'b1; i++) tick(1);
    for (i = 0; i < 2 * PER && pu !== 1'b1; i++) tick(1);
    while (pu === 1'b1 && w < PER) begin
      tick(1);
      w++;
    end
  endtask
  task automatic restart();
    supply_undervoltage_lockout <= 1'b1;
    tick(5);
    supply_undervoltage_lockout <= 1'b0;
    tick(6);
    chk(sw, 1'b1);
    chk(lim < 8'h20, 1'b1);
    tick(SOFT + 2 * PER);
  endtask
  // Counted off the sampling edge so the tasks read it without a race
  always @(negedge clk) cyc++;
  always @(posedge clk) begin
    if (pu === 1'b1 && pd === 1'b1) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, {pu, pd}, 2'h2);
    end
    if (cyc == 40000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic t_start();
    int w, t0;
    chk(sw, 1'b0);
    supply_undervoltage_lockout <= 1'b0;
    tick(8);
    chk(sw, 1'b1);
    chk(lim < 8'h20, 1'b1);
    tick(SOFT + 2 * PER);
    chk(lim == 8'hff, 1'b1);
    pulse(w);
    t0 = cyc - w;
    pulse(w);
    chk_rng(cyc - w - t0, PER, PER);
    $display("test start done");
  endtask
  task automatic t_width();
    int w;
    pulse(w);
    chk_rng(w, PER * 3 / 4 - 8, PER * 3 / 4 + 2);
    fb <= 8'h80;
    tick(1);
    pulse(w);
    chk_rng(w, BLANK_CYC, PER * 3 / 4 - 20);
    chk(slope == 8'h00, 1'b1);
    fb <= 8'hff;
    force_cs <= 1'b1;
    pulse(w);
    chk_rng(w, BLANK_CYC - 6, BLANK_CYC + 6);
    force_cs <= 1'b0;
    tick(4);
    chk(pd, 1'b1);
    pulse(w);
    tick(PER - 60);
    chk(slope != 8'h00, 1'b1);
    chk(pd, 1'b0);
    $display("test width done");
  endtask
  task automatic t_faults();
    ovl <= 1'b1;
    tick(DEB / 2);
    ovl <= 1'b0;
    tick(4);
    chk(sw, 1'b1);
    ovl <= 1'b1;
    tick(DEB + 10);
    chk(sw, 1'b0);
    chk(pu, 1'b0);
    ovl <= 1'b0;
    tick(PER);
    chk(sw, 1'b0);
    restart();
    otp <= 1'b1;
    tick(6);
    chk(pu, 1'b0);
    otp <= 1'b0;
    tick(PER);
    chk(sw, 1'b0);
    restart();
    supply_overvoltage_shutdown <= 1'b1;
    tick(6);
    chk(pu, 1'b0);
    supply_overvoltage_shutdown <= 1'b0;
    tick(PER);
    chk(sw, 1'b0);
    rst8 <= 1'b1;
    tick(6);
    rst8 <= 1'b0;
    chk(sw, 1'b1);
    chk(lim < 8'h20, 1'b1);
    tick(SOFT + 2 * PER);
    $display("test faults done");
  endtask
  task automatic t_burst();
    int w;
    bl <= 1'b1;
    tick(PER);
    pulse(w);
    chk_rng(w, 0, 0);
    bb <= 1'b1;
    pulse(w);
    chk_rng(w, 1, PER);
    bl <= 1'b0;
    bb <= 1'b0;
    $display("test burst done");
  endtask
  initial begin
    tick(8);
    rst_b <= 1'b1;
    tick(2);
    t_start();
    t_width();
    t_faults();
    t_burst();
    print_verdict();
  end
endmodule

// >>> test/power_stage_model.sv
// Behavioural converter power stage: sense current ramp and the two comparators.
// Assumes the control block's gate and code outputs on the same clock.
`timescale 1ns/1ns
module power_stage_model (
  input wire logic i_ref_clk,
  input wire logic i_pullup_on,
  input wire logic [7:0] i_cs_limit_code,
  input wire logic [7:0] i_slope_code,
  input wire logic [7:0] i_fb_level,
  input wire logic i_force_cs,
  output logic o_cs_trip,
  output logic o_pwm_trip
);
  logic [8:0] cur_r;
  // Current builds only while the switch conducts
  always_ff @(posedge i_ref_clk) begin
    cur_r <= i_pullup_on ? ((cur_r == 9'h1ff) ? cur_r : cur_r + 9'h001) : 9'h000;
  end
  // Forced trip mimics the turn-on spike
  assign o_cs_trip = i_force_cs | (i_pullup_on & (cur_r >= {1'b0, i_cs_limit_code}));
  // Feedback level is scaled by two so full-scale feedback lets maximum duty end the pulse
  assign o_pwm_trip = i_pullup_on & (({1'b0, cur_r} + {2'b00, i_slope_code}) >= {1'b0, i_fb_level, 1'b0});
endmodule
